// ==== logic/mdiv_core.sv ====
// Multiply and divide unit beside the integer pipeline
`timescale 1ns/1ps
`default_nettype none
`include "mdiv_consts.svh"

module mdiv_core
  import mdiv_pkg::*;
#(
  parameter int unsigned GPR_AW = 5
) (
  input  wire logic              clk_i,
  input  wire logic              rst_i,
  input  wire logic              issue_valid_i,
  input  wire mdiv_op_t          issue_op_i,
  input  wire logic              issue_signed_i,
  input  wire logic [31:0]       first_source_operand_i,
  input  wire logic [31:0]       second_source_operand_i,
  input  wire logic [GPR_AW-1:0] issue_dest_i,
  output logic                   stall_o,
  output logic                   div_busy_o,
  output logic                   gpr_we_o,
  output logic [GPR_AW-1:0]      gpr_waddr_o,
  output logic [31:0]            gpr_wdata_o,
  output logic [31:0]            high_result_o,
  output logic [31:0]            low_result_o
);

  if (GPR_AW < 1 || GPR_AW > 8) begin : g_bad_aw
    $error("GPR_AW out of range");
  end

  // Each repeat count must leave room for its iterations
  if (`MDIV_DREP_W8  < `MDIV_WORD_BITS - `MDIV_SKIP_W8  ||
      `MDIV_DREP_W16 < `MDIV_WORD_BITS - `MDIV_SKIP_W16 ||
      `MDIV_DREP_W24 < `MDIV_WORD_BITS - `MDIV_SKIP_W24 ||
      `MDIV_DREP_W32 < `MDIV_WORD_BITS - `MDIV_SKIP_W32) begin : g_bad_rep
    $error("Divide repeat shorter than its iterations");
  end

  // Short local names; only src_b decides the multiply size
  logic [31:0] src_a;
  logic [31:0] src_b;
  assign src_a = first_source_operand_i;
  assign src_b = second_source_operand_i;

  // Registers
  logic              stall_q;
  logic              p2_q;
  logic [32:0]       a_q;
  logic [16:0]       bhi_q;
  logic [63:0]       p1_q;
  logic              madd_q;
  logic              msub_q;
  logic              rmul_q;
  logic [GPR_AW-1:0] dest_q;
  logic [31:0]       high_result_q;
  logic [31:0]       low_result_q;
  logic              wb_v_q;
  logic [GPR_AW-1:0] wb_a_q;
  logic [31:0]       wb_d_q;
  logic              gpr_we_q;
  logic [GPR_AW-1:0] gpr_waddr_q;
  logic [31:0]       gpr_wdata_q;
  mdiv_dstate_t      dstate_q;
  mdiv_dstate_t      dstate_d;
  logic [5:0]        cnt_q;
  logic [5:0]        cnt_d;
  logic [5:0]        iter_q;
  logic [31:0]       rem_q;
  logic [31:0]       quo_q;
  logic [31:0]       dvs_q;
  logic              qneg_q;
  logic              rneg_q;
  logic              div_busy_q;

  // Issue decode; a stalled issue is simply not taken
  wire accept  = issue_valid_i & ~stall_q;
  wire is_mhi  = issue_op_i == MDIV_MOVE_FROM_HIGH;
  wire is_mlo  = issue_op_i == MDIV_MOVE_FROM_LOW;
  wire is_madd = issue_op_i == MDIV_MULTIPLY_ADD;
  wire is_msub = issue_op_i == MDIV_MULTIPLY_SUB;
  wire is_rmul = issue_op_i == MDIV_REG_MULTIPLY;
  wire is_div  = issue_op_i == MDIV_DIVIDE;
  wire is_mul  = is_madd | is_msub | is_rmul | (issue_op_i == MDIV_PAIR_MULTIPLY);
  wire sgn     = issue_signed_i;
  wire take_mul = accept & is_mul;
  wire take_div = accept & is_div;

  // Operand size from the value of the second operand only; the first never matters
  wire b_sext16 = (&src_b[31:`MDIV_SIGN16_LSB]) | ~(|src_b[31:`MDIV_SIGN16_LSB]);
  wire b_zext16 = ~(|src_b[31:`MDIV_HALF_BITS]);
  wire b_narrow = sgn ? b_sext16 : b_zext16;

  // One shared 33x17 signed array serves both passes
  // Low half of a wide second operand is unsigned; its sign rides in the upper pass
  wire [32:0] a_in   = {sgn & src_a[31], src_a};
  wire [16:0] b_low  = b_narrow ? src_b[16:0] : {1'b0, src_b[15:0]};
  wire [32:0] mult_a = p2_q ? a_q : a_in;
  wire [16:0] mult_b = p2_q ? bhi_q : b_low;
  wire signed [49:0] prod = $signed(mult_a) * $signed(mult_b);
  wire [63:0] prod64 = {{14{prod[49]}}, prod};
  wire [63:0] upper  = {prod64[47:0], {`MDIV_HALF_BITS{1'b0}}};
  wire [63:0] fin    = p2_q ? p1_q + upper : prod64;

  wire p2_d      = take_mul & ~b_narrow;
  wire fin_valid = p2_q | (take_mul & b_narrow);
  wire fin_add   = p2_q ? madd_q : is_madd;
  wire fin_sub   = p2_q ? msub_q : is_msub;
  wire fin_reg   = p2_q ? rmul_q : is_rmul;
  wire [GPR_AW-1:0] fin_dest = p2_q ? dest_q : issue_dest_i;

  // Dividend width class from its sign extension
  wire s8  = (&src_a[31:`MDIV_SIGN8_LSB])  | ~(|src_a[31:`MDIV_SIGN8_LSB]);
  wire s16 = (&src_a[31:`MDIV_SIGN16_LSB]) | ~(|src_a[31:`MDIV_SIGN16_LSB]);
  wire s24 = (&src_a[31:`MDIV_SIGN24_LSB]) | ~(|src_a[31:`MDIV_SIGN24_LSB]);
  wire w8  = sgn ? s8  : ~(|src_a[31:`MDIV_SIGN8_LSB + 1]);
  wire w16 = sgn ? s16 : ~(|src_a[31:`MDIV_SIGN16_LSB + 1]);
  wire w24 = sgn ? s24 : ~(|src_a[31:`MDIV_SIGN24_LSB + 1]);
  wire [5:0] skip = w8  ? `MDIV_SKIP_W8  :
                    w16 ? `MDIV_SKIP_W16 :
                    w24 ? `MDIV_SKIP_W24 : `MDIV_SKIP_W32;
  wire [5:0] drep = w8  ? `MDIV_DREP_W8  :
                    w16 ? `MDIV_DREP_W16 :
                    w24 ? `MDIV_DREP_W24 : `MDIV_DREP_W32;
  wire [5:0] iters = `MDIV_WORD_BITS - skip;

  // Divide by zero leaves an undefined pair and raises no trap
  // Magnitudes only; signs are restored at commit
  wire        neg_a = sgn & src_a[31];
  wire        neg_b = sgn & src_b[31];
  wire [31:0] dmag  = neg_a ? 32'(-src_a) : src_a;
  wire [31:0] vmag  = neg_b ? 32'(-src_b) : src_b;
  // Top bits of a narrow magnitude are zero, so pre-shift them out
  wire [31:0] dsh   = dmag << skip;

  // One restoring step per clock
  wire        iterating = dstate_q == MDIV_DIV_ITER;
  wire [32:0] shr   = {rem_q, quo_q[31]};
  wire [32:0] diff  = shr - {1'b0, dvs_q};
  wire        ge    = ~diff[32];
  wire [31:0] rem_d = iterating ? (ge ? diff[31:0] : shr[31:0]) : rem_q;
  wire [31:0] quo_d = iterating ? {quo_q[30:0], ge} : quo_q;
  wire [31:0] q_fix = qneg_q ? 32'(-quo_d) : quo_d;
  wire [31:0] r_fix = rneg_q ? 32'(-rem_d) : rem_d;
  wire        div_commit = (dstate_q != MDIV_DIV_IDLE) && (cnt_q == `MDIV_CNT_ONE);

  // Result committing this edge is forwarded to readers of the pair
  wire [63:0] hilo_eff = div_commit ? {r_fix, q_fix} : {high_result_q, low_result_q};
  wire [63:0] acc = fin_add ? hilo_eff + fin :
                    fin_sub ? hilo_eff - fin : fin;
  wire        hilo_mul = fin_valid & ~fin_reg;

  wire move_take = accept & (is_mhi | is_mlo);
  wire mul_wb    = fin_valid & fin_reg;

  // Repeat counter: the issue stall and the commit both key off it
  always_comb begin
    cnt_d = cnt_q;
    if (take_div) begin
      cnt_d = drep;
    end else if (cnt_q != `MDIV_CNT_ZERO) begin
      cnt_d = cnt_q - `MDIV_CNT_ONE;
    end
  end

  always_comb begin
    dstate_d = dstate_q;
    if (take_div) begin
      dstate_d = MDIV_DIV_ITER;
    end else begin
      unique case (dstate_q)
        MDIV_DIV_IDLE: dstate_d = MDIV_DIV_IDLE;
        MDIV_DIV_ITER: begin
          if (cnt_q == `MDIV_CNT_ONE) begin
            dstate_d = MDIV_DIV_IDLE;
          end else if (iter_q == `MDIV_CNT_ONE) begin
            dstate_d = MDIV_DIV_WAIT;
          end
        end
        MDIV_DIV_WAIT: begin
          if (cnt_q == `MDIV_CNT_ONE) begin
            dstate_d = MDIV_DIV_IDLE;
          end
        end
        default: dstate_d = MDIV_DIV_IDLE;
      endcase
    end
  end

  // Stall covers the second multiply pass and the divide body
  // A registered stall cannot see the next op, so a wide pass blocks any op
  wire stall_d = p2_d | (cnt_d > `MDIV_CNT_ONE);

  // No stall input: this pipeline never waits for the integer one
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      stall_q    <= 1'b0;
      p2_q       <= 1'b0;
      dstate_q   <= MDIV_DIV_IDLE;
      cnt_q      <= `MDIV_CNT_ZERO;
      div_busy_q <= 1'b0;
    end else begin
      stall_q    <= stall_d;
      p2_q       <= p2_d;
      dstate_q   <= dstate_d;
      cnt_q      <= cnt_d;
      div_busy_q <= dstate_d != MDIV_DIV_IDLE;
    end
  end

  // First pass of a wide multiply
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      a_q    <= 33'h0_0000_0000;
      bhi_q  <= 17'h0_0000;
      p1_q   <= `MDIV_PART_RST;
      madd_q <= 1'b0;
      msub_q <= 1'b0;
      rmul_q <= 1'b0;
      dest_q <= '0;
    end else if (p2_d) begin
      a_q    <= a_in;
      bhi_q  <= {sgn & src_b[31], src_b[31:16]};
      p1_q   <= prod64;
      madd_q <= is_madd;
      msub_q <= is_msub;
      rmul_q <= is_rmul;
      dest_q <= issue_dest_i;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      iter_q <= `MDIV_CNT_ZERO;
      rem_q  <= `MDIV_WORD_RST;
      quo_q  <= `MDIV_WORD_RST;
      dvs_q  <= `MDIV_WORD_RST;
      qneg_q <= 1'b0;
      rneg_q <= 1'b0;
    end else if (take_div) begin
      iter_q <= iters;
      rem_q  <= `MDIV_WORD_RST;
      quo_q  <= dsh;
      dvs_q  <= vmag;
      qneg_q <= neg_a ^ neg_b;
      rneg_q <= neg_a;
    end else if (iterating) begin
      iter_q <= iter_q - `MDIV_CNT_ONE;
      rem_q  <= rem_d;
      quo_q  <= quo_d;
    end
  end

  // Later multiply wins over a divide committing on the same edge
  // Register multiplies leave the pair untouched
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      high_result_q <= `MDIV_WORD_RST;
      low_result_q  <= `MDIV_WORD_RST;
    end else if (hilo_mul) begin
      high_result_q <= acc[63:32];
      low_result_q  <= acc[31:0];
    end else if (div_commit) begin
      high_result_q <= r_fix;
      low_result_q  <= q_fix;
    end
  end

  // Write-back stage, then the output flops
  // Moves and register multiplies share one port; the stall keeps them apart
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_v_q      <= 1'b0;
      wb_a_q      <= '0;
      wb_d_q      <= `MDIV_WORD_RST;
      gpr_we_q    <= 1'b0;
      gpr_waddr_q <= '0;
      gpr_wdata_q <= `MDIV_WORD_RST;
    end else begin
      wb_v_q <= mul_wb | move_take;
      if (mul_wb) begin
        wb_a_q <= fin_dest;
        wb_d_q <= fin[31:0];
      end else if (move_take) begin
        wb_a_q <= issue_dest_i;
        wb_d_q <= is_mhi ? hilo_eff[63:32] : hilo_eff[31:0];
      end
      gpr_we_q    <= wb_v_q;
      gpr_waddr_q <= wb_a_q;
      gpr_wdata_q <= wb_d_q;
    end
  end

  assign stall_o       = stall_q;
  assign div_busy_o    = div_busy_q;
  assign gpr_we_o      = gpr_we_q;
  assign gpr_waddr_o   = gpr_waddr_q;
  assign gpr_wdata_o   = gpr_wdata_q;
  assign high_result_o = high_result_q;
  assign low_result_o  = low_result_q;

endmodule

`default_nettype wire

// ==== logic/mdiv_consts.svh ====
// Constants for the multiply and divide unit
// Behaviour
// - Own pipeline keeps advancing while integer pipeline stalls
// - 33x17 signed array; second operand width sets passes
// - Narrow multiply every cycle, wide every other
// - Multiply size found from operand values
// - Divider resolves one quotient bit per clock
// - Narrow dividends skip 23, 15 or 7 iterations
// - Any op during divide stalls until done
// - Multiply latency and repeat per operand size
// - Divide latency and repeat per dividend width
// - Results into pair; move ops copy out
// - Register multiply writes low product to register
// - Multiply-add adds product to pair
// - Multiply-subtract subtracts product from pair
`ifndef MDIV_CONSTS_SVH
`define MDIV_CONSTS_SVH

`define MDIV_WORD_BITS   6'd32
`define MDIV_SKIP_W8     6'd23
`define MDIV_SKIP_W16    6'd15
`define MDIV_SKIP_W24    6'd7
`define MDIV_SKIP_W32    6'd0
// Repeat counts; latency is always one more
`define MDIV_DREP_W8     6'd11
`define MDIV_DREP_W16    6'd18
`define MDIV_DREP_W24    6'd25
`define MDIV_DREP_W32    6'd32
`define MDIV_CNT_ONE     6'd1
`define MDIV_CNT_ZERO    6'd0
`define MDIV_WORD_RST    32'h0000_0000
`define MDIV_PART_RST    64'h0000_0000_0000_0000
`define MDIV_SIGN8_LSB   7
`define MDIV_SIGN16_LSB  15
`define MDIV_SIGN24_LSB  23
`define MDIV_HALF_BITS   16

`endif

// ==== logic/mdiv_pkg.sv ====
// Types of the multiply and divide unit
package mdiv_pkg;

  typedef enum logic [2:0] {
    MDIV_MOVE_FROM_HIGH = 3'h0,
    MDIV_MOVE_FROM_LOW  = 3'h1,
    MDIV_PAIR_MULTIPLY  = 3'h2,
    MDIV_MULTIPLY_ADD   = 3'h3,
    MDIV_MULTIPLY_SUB   = 3'h4,
    MDIV_REG_MULTIPLY   = 3'h5,
    MDIV_DIVIDE         = 3'h6
  } mdiv_op_t;

  typedef enum logic [1:0] {
    MDIV_DIV_IDLE = 2'b00,
    MDIV_DIV_ITER = 2'b01,
    MDIV_DIV_WAIT = 2'b11
  } mdiv_dstate_t;

endpackage

// ==== test/mdiv_core_assertions.sv ====
// Port-level checks of the multiply and divide unit
`timescale 1ns/1ps
`default_nettype none
module mdiv_core_assertions
  import mdiv_pkg::*;
#(
  parameter int unsigned GPR_AW = 5
) (
  input wire logic              clk_i,
  input wire logic              rst_i,
  input wire logic              issue_valid_i,
  input wire mdiv_op_t          issue_op_i,
  input wire logic              issue_signed_i,
  input wire logic [31:0]       first_source_operand_i,
  input wire logic [31:0]       second_source_operand_i,
  input wire logic [GPR_AW-1:0] issue_dest_i,
  input wire logic              stall_o,
  input wire logic              div_busy_o,
  input wire logic              gpr_we_o,
  input wire logic [GPR_AW-1:0] gpr_waddr_o,
  input wire logic [31:0]       gpr_wdata_o,
  input wire logic [31:0]       high_result_o,
  input wire logic [31:0]       low_result_o
);
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);
  function automatic logic fit(input logic [31:0] v, input int n, input logic s);
    return ((s ? v + (32'h1 << (n - 1)) : v) >> n) == 32'h0;
  endfunction
  wire        tk = issue_valid_i && !stall_o;
  wire [31:0] a = first_source_operand_i;
  wire [31:0] b = second_source_operand_i;
  wire        s = issue_signed_i;
  wire        nar = fit(b, 16, s);
  wire [63:0] pr = (s ? {{32{a[31]}}, a} : {32'h0, a}) * (s ? {{32{b[31]}}, b} : {32'h0, b});
  wire [31:0] prl = pr[31:0];
  wire [63:0] pair = {high_result_o, low_result_o};
  wire        pm = tk && issue_op_i == MDIV_PAIR_MULTIPLY;
  wire        wide = tk && !nar && issue_op_i inside {MDIV_PAIR_MULTIPLY, MDIV_MULTIPLY_ADD,
                                                      MDIV_MULTIPLY_SUB, MDIV_REG_MULTIPLY};
  logic [5:0] cnt_q;
  // Tracks the expected busy window so its length is checked, not just its presence
  always_ff @(posedge clk_i) begin
    if (rst_i)
      cnt_q <= 6'h00;
    else if (tk && issue_op_i == MDIV_DIVIDE)
      cnt_q <= fit(a, 8, s) ? 6'h0b : fit(a, 16, s) ? 6'h12 : fit(a, 24, s) ? 6'h19 : 6'h20;
    else if (cnt_q != 6'h00)
      cnt_q <= cnt_q - 6'h01;
  end
  property p_wide_gap; wide |=> stall_o; endproperty
  a_wide_gap: assert property (p_wide_gap) else $error("wide gap");
  property p_wide_res; pm && !nar |=> ##1 pair == $past(pr, 2); endproperty
  a_wide_res: assert property (p_wide_res) else $error("wide product");
  property p_nar_res; pm && nar |=> pair == $past(pr) && !stall_o; endproperty
  a_nar_res: assert property (p_nar_res) else $error("narrow product");
  property p_acc; tk && nar && issue_op_i inside {MDIV_MULTIPLY_ADD, MDIV_MULTIPLY_SUB} |=>
    pair == $past(pair) + ($past(issue_op_i) == MDIV_MULTIPLY_ADD ? $past(pr) : -$past(pr));
  endproperty
  a_acc: assert property (p_acc) else $error("accumulate");
  property p_reg; tk && nar && issue_op_i == MDIV_REG_MULTIPLY |=> ##1 gpr_we_o &&
    gpr_wdata_o == $past(prl, 2) && gpr_waddr_o == $past(issue_dest_i, 2); endproperty
  a_reg: assert property (p_reg) else $error("register multiply");
  property p_move; tk && issue_op_i inside {MDIV_MOVE_FROM_HIGH, MDIV_MOVE_FROM_LOW} |=> ##1
    gpr_we_o && gpr_wdata_o == ($past(issue_op_i, 2) == MDIV_MOVE_FROM_LOW ?
    $past(low_result_o) : $past(high_result_o)); endproperty
  a_move: assert property (p_move) else $error("move");
  property p_busy; div_busy_o == (cnt_q != 6'h00); endproperty
  a_busy: assert property (p_busy) else $error("divide window");
  property p_lock; cnt_q > 6'h01 |-> stall_o; endproperty
  a_lock: assert property (p_lock) else $error("divide interlock");
endmodule
bind mdiv_core mdiv_core_assertions #(.GPR_AW(GPR_AW)) i_chk (
  .clk_i, .rst_i, .issue_valid_i, .issue_op_i, .issue_signed_i, .first_source_operand_i,
  .second_source_operand_i, .issue_dest_i, .stall_o, .div_busy_o, .gpr_we_o, .gpr_waddr_o,
  .gpr_wdata_o, .high_result_o, .low_result_o
);
`default_nettype wire

// ==== test/mdiv_pipe_model.sv ====
// Integer pipeline stand-in that offers operations to the unit
`timescale 1ns/1ps
`default_nettype none
module mdiv_pipe_model
  import mdiv_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        stall_i,
  output var  logic        valid_o,
  output var  mdiv_op_t    op_o,
  output var  logic        sgn_o,
  output var  logic [31:0] a_o,
  output var  logic [31:0] b_o,
  output var  logic [4:0]  dest_o
);
  initial begin
    {valid_o, sgn_o, a_o, b_o, dest_o} = '0;
    op_o = MDIV_MOVE_FROM_HIGH;
  end
  // Entered at a falling edge; hold keeps valid up for a back-to-back offer
  task automatic issue(input mdiv_op_t op, input logic s, input logic [31:0] a,
                       input logic [31:0] b, input logic [4:0] d, input bit hold);
    bit t;
    int n;
    valid_o = 1'b1;
    op_o    = op;
    sgn_o   = s;
    a_o     = a;
    b_o     = b;
    dest_o  = d;
    n = 0;
    do begin
      t = !stall_i;
      @(posedge clk_i);
      @(negedge clk_i);
      n++;
    end while (!t && n < 64);
    // Released operands are inverted so a stale value cannot pass
    if (!hold)
      {valid_o, a_o, b_o} = {1'b0, ~a, ~b};
  endtask
endmodule
`default_nettype wire

// ==== test/testbench.sv ====
// Self-checking bench for the multiply and divide unit
`timescale 1ns/1ps
`default_nettype none
`define CHK(act, exp) begin total_checks++; if ((act) !== (exp)) begin bad_count++; \
  $display("[ERR] %0t got %h exp %h", $time, (act), (exp)); end end
module testbench
  import mdiv_pkg::*;
;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        issue_valid_i, issue_signed_i, stall_o, div_busy_o, gpr_we_o;
  mdiv_op_t    issue_op_i;
  logic [31:0] first_source_operand_i, second_source_operand_i, gpr_wdata_o;
  logic [31:0] high_result_o, low_result_o;
  logic [4:0]  issue_dest_i, gpr_waddr_o;
  wire  [63:0] pair = {high_result_o, low_result_o};
  int          bad_count = 0, total_checks = 0, cyc = 0;
  mdiv_core i_dut (
    .clk_i, .rst_i, .issue_valid_i, .issue_op_i, .issue_signed_i, .first_source_operand_i,
    .second_source_operand_i, .issue_dest_i, .stall_o, .div_busy_o, .gpr_we_o, .gpr_waddr_o,
    .gpr_wdata_o, .high_result_o, .low_result_o
  );
  mdiv_pipe_model i_pipe (
    .clk_i, .stall_i(stall_o), .valid_o(issue_valid_i), .op_o(issue_op_i),
    .sgn_o(issue_signed_i), .a_o(first_source_operand_i), .b_o(second_source_operand_i),
    .dest_o(issue_dest_i)
  );
  always #2.5 clk_i = ~clk_i;
  always @(posedge clk_i) begin
    cyc++;
    if (cyc == 2000) begin
      bad_count++;
      test_done();
    end
  end
  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, bad_count);
    if (bad_count == 0 && total_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic t_mul();
    int c;
    c = cyc;
    i_pipe.issue(MDIV_PAIR_MULTIPLY, 1'b0, 32'hffff_fff0, 32'h0000_ffff, 5'h00, 1'b1);
    i_pipe.issue(MDIV_PAIR_MULTIPLY, 1'b1, 32'h8000_0000, 32'h0000_7fff, 5'h00, 1'b1);
    `CHK(cyc - c, 2)
    `CHK(pair, 64'hffff_c000_8000_0000)
    c = cyc;
    i_pipe.issue(MDIV_PAIR_MULTIPLY, 1'b1, 32'hffff_fffe, 32'h0001_0000, 5'h00, 1'b1);
    `CHK(stall_o, 1'b1)
    i_pipe.issue(MDIV_PAIR_MULTIPLY, 1'b0, 32'h0001_0001, 32'h8000_0000, 5'h00, 1'b0);
    `CHK(cyc - c, 3)
    `CHK(pair, 64'hffff_ffff_fffe_0000)
    @(negedge clk_i);
    `CHK(pair, 64'h0000_8000_8000_0000)
  endtask
  task automatic t_acc();
    logic [63:0] e;
    e = 64'h0 - 64'd21 - 64'h2468_acf0 - 64'd500;
    i_pipe.issue(MDIV_PAIR_MULTIPLY, 1'b1, 32'hffff_fffd, 32'h0000_0007, 5'h00, 1'b1);
    i_pipe.issue(MDIV_MULTIPLY_ADD, 1'b1, 32'h1234_5678, 32'hffff_fffe, 5'h00, 1'b1);
    i_pipe.issue(MDIV_MULTIPLY_SUB, 1'b1, 32'h0000_0064, 32'h0000_0005, 5'h00, 1'b1);
    i_pipe.issue(MDIV_MOVE_FROM_HIGH, 1'b0, 32'h0, 32'h0, 5'h1a, 1'b0);
    `CHK(pair, e)
    @(negedge clk_i);
    `CHK({gpr_we_o, gpr_waddr_o, gpr_wdata_o}, {1'b1, 5'h1a, e[63:32]})
  endtask
  task automatic t_reg(input logic [31:0] a, input logic [31:0] b, input int w);
    logic [63:0] p;
    p = pair;
    i_pipe.issue(MDIV_REG_MULTIPLY, 1'b0, a, b, 5'h13, 1'b0);
    repeat (w) @(negedge clk_i);
    `CHK({gpr_we_o, gpr_waddr_o, gpr_wdata_o, pair}, {1'b1, 5'h13, a * b, p})
  endtask
  task automatic t_div(input logic [31:0] a, input logic [31:0] b, input logic s, input int r);
    int c;
    logic [31:0] q, m;
    if (s) begin
      q = $signed(a) / $signed(b);
      m = $signed(a) % $signed(b);
    end else begin
      q = a / b;
      m = a % b;
    end
    c = cyc;
    i_pipe.issue(MDIV_DIVIDE, s, a, b, 5'h00, 1'b1);
    `CHK({div_busy_o, stall_o}, 2'b11)
    i_pipe.issue(MDIV_MOVE_FROM_LOW, 1'b0, 32'h0, 32'h0, 5'h07, 1'b0);
    `CHK(cyc - c, r + 1)
    @(negedge clk_i);
    `CHK({gpr_we_o, gpr_wdata_o, high_result_o}, {1'b1, q, m})
  endtask
  initial begin
    repeat (2) @(negedge clk_i);
    rst_i = 1'b0;
    @(negedge clk_i);
    t_mul();
    t_acc();
    t_reg(32'hdead_beef, 32'h0000_1234, 1);
    t_reg(32'h0001_2345, 32'h0002_0001, 2);
    t_div(32'h0000_0064, 32'h0000_0007, 1'b0, 11);
    t_div(32'hffff_ff80, 32'h0000_0003, 1'b1, 11);
    t_div(32'h0000_00ff, 32'hffff_fffd, 1'b1, 18);
    t_div(32'hffff_8001, 32'h0000_0013, 1'b1, 18);
    t_div(32'h00ab_cdef, 32'h0000_0123, 1'b0, 25);
    t_div(32'h8000_0001, 32'hffff_fffb, 1'b1, 32);
    test_done();
  end
endmodule
`default_nettype wire
